// >>> rtl/dvb_host.sv
// Controller outside the dual-vector / direct-transfer request front end:
// arbitrator, interrupt fielding and direct-transfer requesting function.
// Assumes software on Avalon-MM and asynchronous bus pins from the device.
//
// Overview of operation
// - After acknowledge, the arbitrator withdraws grant and stops arbitrating.
// - Requester withdraws request after each transfer, reasserts for the next; in burst mode it stays up between cycles.
// - Requester holds its request until the transfer completes.
// - For multi-cycle ownership, permit is withheld until the last cycle begins.
//
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
module dvb_host
    import dvb_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        bus_request_pin,
    input  wire logic        sack_pin,
    input  wire logic        bbsy_pin,
    input  wire logic        intr_pin,
    input  wire logic        grant_out_pin,
    input  wire logic        dma_owner_active_n_pin,
    input  wire logic [8:2]  vector_pin,
    output logic             bus_grant,
    output logic             npr_grant,
    output logic             chan_a_irq_enable,
    output logic             chan_b_irq_enable,
    output logic             irq_cond_a,
    output logic             irq_cond_b,
    output logic             dma_cycle_request_n,
    output logic             ack_release_permit_n,
    output logic             transfer_done_flag,
    output logic             slave_sync
);
    // ==================================================================
    // Pin synchronisation
    logic [12:0] pins_s;
    logic        br_s;
    logic        sack_s;
    logic        bbsy_s;
    logic        intr_s;
    logic        gout_s;
    logic        owner_s;
    logic [8:2]  vec_s;

    dvb_sync #(.WIDTH(13)) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin     ({vector_pin, !dma_owner_active_n_pin, grant_out_pin,
                   intr_pin, bbsy_pin, sack_pin, bus_request_pin}),
        .sync    (pins_s)
    );
    assign {vec_s, owner_s, gout_s, intr_s, bbsy_s, sack_s, br_s} = pins_s;

    // ==================================================================
    // Register state
    logic [5:0] ctrl;
    logic [7:0] count;
    logic       go;
    logic       vec_valid;
    logic [8:0] vector;
    logic       wr_acc;
    logic       rd_acc;
    logic       vec_capture;
    logic       dma_busy;
    logic [7:0] dma_done;
    logic       dma_ssyn;
    logic       dma_fin;
    logic       dma_req_n;
    logic       dma_permit_n;
    dvb_arb_t   arb;

    assign wr_acc = avs_write && !avs_waitrequest;
    assign rd_acc = avs_read && !avs_waitrequest;

    // ==================================================================
    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
        begin
            unique case (avs_address)
                OFS_CTRL:   avs_readdata <= {26'h000_0000, ctrl};
                OFS_COUNT:  avs_readdata <= {24'h00_0000, count};
                OFS_STATUS: avs_readdata <= {16'h0000, dma_done, 5'h00, vec_valid,
                                             arb == ARB_SUSPEND, dma_busy};
                OFS_VECTOR: avs_readdata <= {23'h00_0000, vector};
                default:    avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl  <= CTRL_RESET;
            count <= COUNT_RESET;
            go    <= 1'b0;
        end
        else
        begin
            go <= wr_acc && avs_address == OFS_GO && avs_writedata[0];
            if (wr_acc && avs_address == OFS_CTRL)
                ctrl <= avs_writedata[5:0];
            if (wr_acc && avs_address == OFS_COUNT)
                count <= avs_writedata[7:0];
        end
    end

    // ==================================================================
    // Interrupt channel drive
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            chan_a_irq_enable <= 1'b0;
            chan_b_irq_enable <= 1'b0;
            irq_cond_a        <= 1'b0;
            irq_cond_b        <= 1'b0;
        end
        else
        begin
            chan_a_irq_enable <= ctrl[CTRL_EN_A];
            chan_b_irq_enable <= ctrl[CTRL_EN_B];
            irq_cond_a        <= ctrl[CTRL_COND_A];
            irq_cond_b        <= ctrl[CTRL_COND_B];
        end
    end

    // ==================================================================
    // Arbitrator
    logic [3:0] hold_cnt;
    logic       bus_free;
    logic       dma_want;

    assign bus_free = !sack_s && !bbsy_s && ctrl[CTRL_ARB_EN];
    assign dma_want = !dma_req_n;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            arb      <= ARB_IDLE;
            hold_cnt <= 4'h0;
        end
        else
        begin
            unique case (arb)
                ARB_IDLE:
                    // Direct transfers outrank interrupt requests
                    if (bus_free && dma_want)
                        arb <= ARB_GNT_NP;
                    else if (bus_free && br_s)
                        arb <= ARB_GNT_BR;
                ARB_GNT_BR, ARB_GNT_NP:
                begin
                    hold_cnt <= 4'h0;
                    if (sack_s)
                        arb <= ARB_HOLD;
                    else if (gout_s)
                        arb <= ARB_IDLE;
                end
                ARB_HOLD:
                    if (hold_cnt == 4'(GRANT_HOLD_CYC - 1))
                        arb <= ARB_SUSPEND;
                    else
                        hold_cnt <= hold_cnt + 4'h1;
                ARB_SUSPEND:
                    if (!sack_s && !bbsy_s)
                        arb <= ARB_IDLE;
                default:
                    arb <= ARB_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            bus_grant <= 1'b0;
            npr_grant <= 1'b0;
        end
        else
        begin
            // Grant kept for the minimum hold after acknowledge
            bus_grant <= (arb == ARB_GNT_BR && !gout_s)
                         || (arb == ARB_IDLE && bus_free && br_s && !dma_want)
                         || (arb == ARB_HOLD && bus_grant
                             && hold_cnt != 4'(GRANT_HOLD_CYC - 1));
            npr_grant <= (arb == ARB_GNT_NP && !gout_s)
                         || (arb == ARB_IDLE && bus_free && dma_want)
                         || (arb == ARB_HOLD && npr_grant
                             && hold_cnt != 4'(GRANT_HOLD_CYC - 1));
        end
    end

    // ==================================================================
    // Interrupt fielding: vector strobe and slave sync
    logic irq_ssyn;

    assign vec_capture = intr_s && bbsy_s && !irq_ssyn;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_ssyn  <= 1'b0;
            vector    <= 9'h000;
            vec_valid <= 1'b0;
        end
        else
        begin
            if (vec_capture)
                vector <= {vec_s, 2'b00};
            // Sync held until the interrupt line drops
            irq_ssyn <= vec_capture || (irq_ssyn && intr_s);
            // Capture beats a clearing read in the same cycle
            if (vec_capture)
                vec_valid <= 1'b1;
            else if (rd_acc && avs_address == OFS_VECTOR)
                vec_valid <= 1'b0;
        end
    end

    // ==================================================================
    // Direct-transfer requester
    dvb_dma_seq u_dma (
        .clk_sys              (clk_sys),
        .resetn               (resetn),
        .start                (go),
        .burst                (ctrl[CTRL_BURST]),
        .count                (count),
        .owner_active         (owner_s),
        .dma_cycle_request_n  (dma_req_n),
        .ack_release_permit_n (dma_permit_n),
        .slave_sync           (dma_ssyn),
        .done_flag            (dma_fin),
        .busy                 (dma_busy),
        .done_count           (dma_done)
    );

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dma_cycle_request_n  <= 1'b1;
            ack_release_permit_n <= 1'b0;
            transfer_done_flag   <= 1'b0;
            slave_sync           <= 1'b0;
        end
        else
        begin
            dma_cycle_request_n  <= dma_req_n;
            ack_release_permit_n <= dma_permit_n;
            transfer_done_flag   <= dma_fin || irq_ssyn;
            slave_sync           <= dma_ssyn || irq_ssyn;
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_GRANT_WITHDRAW: assert property (
        ($rose(sack_s) && (bus_grant || npr_grant)) |-> ##[1:6] !(bus_grant || npr_grant))
        else $error("grant not withdrawn after acknowledge");
    AST_SUSPENDED: assert property (
        (arb == ARB_SUSPEND) |=> !bus_grant && !npr_grant)
        else $error("grant issued while arbitration suspended");
    AST_ONE_GRANT: assert property (
        !(bus_grant && npr_grant))
        else $error("both grants high");
    CVR_NPG: cover property ($rose(npr_grant) ##[1:20] sack_s);
    CVR_VEC: cover property ($rose(vec_valid));
    CVR_SUSP: cover property (arb == ARB_HOLD ##[1:8] arb == ARB_SUSPEND);
endmodule // dvb_host

// >>> shared/dvb_pkg.sv
// Package for the dual-vector / direct-transfer bus request controller.
// Assumes a single 25 MHz system clock and byte addresses on the register bus.
package dvb_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_NS          = 40;
    localparam int GRANT_MIN_NS    = 75;
    localparam int GRANT_HOLD_CYC  = (GRANT_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLAVE_RESP_NS   = 120;
    localparam int SLAVE_RESP_CYC  = (SLAVE_RESP_NS + CLK_NS - 1) / CLK_NS;

    // ==================================================================
    // Register offsets (byte addresses)
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_COUNT  = 5'h04;
    localparam logic [4:0] OFS_GO     = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_VECTOR = 5'h10;

    // ==================================================================
    // Control fields
    localparam int CTRL_EN_A    = 0;
    localparam int CTRL_EN_B    = 1;
    localparam int CTRL_COND_A  = 2;
    localparam int CTRL_COND_B  = 3;
    localparam int CTRL_ARB_EN  = 4;
    localparam int CTRL_BURST   = 5;
    localparam logic [5:0] CTRL_RESET  = 6'h00;
    localparam logic [7:0] COUNT_RESET = 8'h01;

    // Status fields
    localparam int STAT_DMA_BUSY = 0;
    localparam int STAT_SUSPEND  = 1;
    localparam int STAT_VEC_VLD  = 2;
    localparam int STAT_DONE_LSB = 8;

    // ==================================================================
    // State machines
    typedef enum logic [2:0] {
        ARB_IDLE    = 3'b000,
        ARB_GNT_BR  = 3'b001,
        ARB_GNT_NP  = 3'b010,
        ARB_HOLD    = 3'b011,
        ARB_SUSPEND = 3'b100
    } dvb_arb_t;

    typedef enum logic [2:0] {
        DMA_IDLE  = 3'b000,
        DMA_REQ   = 3'b001,
        DMA_XFER  = 3'b010,
        DMA_END   = 3'b011,
        DMA_GAP   = 3'b100
    } dvb_dma_t;

endpackage

// >>> rtl/dvb_sync.sv
// Two-flop synchroniser bank for asynchronous bus pins.
// Assumes pins change freely relative to clk_sys.
`timescale 1ns/1ns
module dvb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] sync
);
    // ==================================================================
    // Per-bit stages
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta;
            always_ff @(posedge clk_sys or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta    <= 1'b0;
                    sync[i] <= 1'b0;
                end
                else
                begin
                    meta    <= pin[i];
                    sync[i] <= meta;
                end
            end
        end
    endgenerate
endmodule // dvb_sync

// >>> rtl/dvb_dma_seq.sv
// Direct-transfer requesting function: drives request, release permit,
// slave sync and done flag. Assumes owner input is already synchronised.
`timescale 1ns/1ns
module dvb_dma_seq
    import dvb_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic       start,
    input  wire logic       burst,
    input  wire logic [7:0] count,
    input  wire logic       owner_active,
    output logic            dma_cycle_request_n,
    output logic            ack_release_permit_n,
    output logic            slave_sync,
    output logic            done_flag,
    output logic            busy,
    output logic [7:0]      done_count
);
    dvb_dma_t   state;
    logic [7:0] remaining;
    logic [3:0] wait_cnt;
    logic       burst_q;

    // ==================================================================
    // Sequencer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state      <= DMA_IDLE;
            remaining  <= 8'h00;
            wait_cnt   <= 4'h0;
            burst_q    <= 1'b0;
            done_count <= 8'h00;
        end
        else
        begin
            unique case (state)
                DMA_IDLE:
                    if (start && count != 8'h00)
                    begin
                        remaining <= count;
                        burst_q   <= burst;
                        state     <= DMA_REQ;
                    end
                DMA_REQ:
                    if (owner_active)
                    begin
                        wait_cnt <= 4'h0;
                        state    <= DMA_XFER;
                    end
                DMA_XFER:
                    if (wait_cnt == 4'(SLAVE_RESP_CYC))
                        state <= DMA_END;
                    else
                        wait_cnt <= wait_cnt + 4'h1;
                DMA_END:
                    if (!owner_active)
                    begin
                        remaining  <= remaining - 8'h01;
                        done_count <= done_count + 8'h01;
                        state      <= DMA_GAP;
                    end
                DMA_GAP:
                    // Multi-cycle ownership keeps the request up between cycles
                    state <= (remaining == 8'h00) ? DMA_IDLE : DMA_REQ;
                default:
                    state <= DMA_IDLE;
            endcase
        end
    end

    // ==================================================================
    // Pin drive
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dma_cycle_request_n  <= 1'b1;
            ack_release_permit_n <= 1'b0;
            slave_sync           <= 1'b0;
            done_flag            <= 1'b0;
            busy                 <= 1'b0;
        end
        else
        begin
            busy <= (state != DMA_IDLE);
            dma_cycle_request_n <= !(state == DMA_REQ || state == DMA_XFER
                                     || state == DMA_END
                                     || (state == DMA_GAP && burst_q && remaining != 8'h00));
            ack_release_permit_n <= (state != DMA_IDLE) && burst_q && (remaining > 8'h01);
            slave_sync <= (state == DMA_XFER && wait_cnt == 4'(SLAVE_RESP_CYC))
                          || (state == DMA_END && owner_active);
            done_flag  <= slave_sync || (state == DMA_XFER && wait_cnt == 4'(SLAVE_RESP_CYC));
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_REQ_HELD: assert property (
        (state == DMA_XFER) |=> !dma_cycle_request_n)
        else $error("request dropped during transfer");
    AST_REQ_DROP: assert property (
        (state == DMA_GAP && (!burst_q || remaining == 8'h00)) |=> dma_cycle_request_n)
        else $error("request not withdrawn after transfer");
    AST_PERMIT_HELD: assert property (
        (state == DMA_REQ && burst_q && remaining > 8'h01) |=> ack_release_permit_n)
        else $error("release permit given before last cycle");
    AST_SYNC_BOUND: assert property (
        $rose(state == DMA_XFER) |-> ##[1:8] slave_sync)
        else $error("slave sync not given in time");
    CVR_BURST: cover property (burst_q && state == DMA_GAP && remaining == 8'h00);
    CVR_SINGLE: cover property (!burst_q && $rose(state == DMA_GAP));
endmodule // dvb_dma_seq

// >>> dv/dvb_dev_model.sv
// Behavioural model of the two-channel and direct-transfer request front end.
// Assumes host pins change on clk_sys; both channels share one request level.
`timescale 1ns/1ns
module dvb_dev_model
(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [8:3] jumper,
    input  wire logic       bus_grant,
    input  wire logic       npr_grant,
    input  wire logic       chan_a_irq_enable,
    input  wire logic       chan_b_irq_enable,
    input  wire logic       irq_cond_a,
    input  wire logic       irq_cond_b,
    input  wire logic       dma_cycle_request_n,
    input  wire logic       ack_release_permit_n,
    input  wire logic       transfer_done_flag,
    input  wire logic       slave_sync,
    output logic            bus_request_pin,
    output logic            sack_pin,
    output logic            bbsy_pin,
    output logic            intr_pin,
    output logic            grant_out_pin,
    output logic            dma_owner_active_n_pin,
    output logic [8:2]      vector_pin
);
    // ==========================================================
    // Ownership: took is 1 for A, 2 for B, 3 for direct transfer
    logic [1:0] pend, req_q, took, tail;
    logic       own, dreq, fin;
    assign dreq = !dma_cycle_request_n;
    assign fin  = own && slave_sync && transfer_done_flag;
    // one shared level and chain, dropped once acknowledged
    assign bus_request_pin = (|pend) && took == 2'd0 && !sack_pin;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            {pend, req_q, took, tail, own, sack_pin, bbsy_pin, intr_pin} <= '0;
            grant_out_pin          <= 1'b0;
            dma_owner_active_n_pin <= 1'b1;
            vector_pin             <= '0;
        end
        else
        begin
            req_q <= {irq_cond_b & chan_b_irq_enable, irq_cond_a & chan_a_irq_enable};
            pend <= (pend | (req_q ^ {irq_cond_b & chan_b_irq_enable,
                    irq_cond_a & chan_a_irq_enable}) & ~req_q)
                    & ~((fin && took != 2'd3) ? took : 2'b00);
            // grant passes only when neither link wants it
            grant_out_pin <= bus_grant && took == 2'd0 && pend == 2'b00;
            // Released data lines toggle so stale values never pass
            if (!own)
                vector_pin <= ~vector_pin;
            if (took == 2'd0 && !sack_pin)
            begin
                // direct grant is blocked and acknowledged
                if (npr_grant && dreq)
                    {took, sack_pin} <= {2'd3, 1'b1};
                // channel A is the first link
                else if (bus_grant && pend[0])
                    {took, sack_pin} <= {2'd1, 1'b1};
                else if (bus_grant && pend[1])
                    {took, sack_pin} <= {2'd2, 1'b1};
            end
            if (took != 2'd0 && !own && !bbsy_pin && !bus_grant && !npr_grant && !slave_sync)
            begin
                {bbsy_pin, own}        <= 2'b11;
                dma_owner_active_n_pin <= took != 2'd3;
                intr_pin               <= took != 2'd3;
                vector_pin             <= {jumper, took != 2'd1};
            end
            // channels tie their permit; only direct transfers use the pin
            if (bbsy_pin && (took != 2'd3 || !ack_release_permit_n) && !bus_grant)
                sack_pin <= 1'b0;
            // ownership ends, busy held two more cycles
            if (fin)
            begin
                {own, intr_pin, dma_owner_active_n_pin} <= 3'b001;
                tail <= 2'd2;
                if (!sack_pin || !ack_release_permit_n)
                    took <= 2'd0;
            end
            if (tail != 2'd0)
                tail <= tail - 2'd1;
            if (tail == 2'd1)
                bbsy_pin <= 1'b0;
            if (took == 2'd3 && !dreq)
            begin
                {took, sack_pin, own, bbsy_pin, tail} <= '0;
                dma_owner_active_n_pin <= 1'b1;
            end
        end
    end
endmodule // dvb_dev_model

// >>> dv/dual_vector_and_dma_bus_request_tb_top.sv
// Self-checking bench for the bus request controller and the device model.
// Assumes Avalon-MM access to the controller's registers only.
`timescale 1ns/1ns
module dual_vector_and_dma_bus_request_tb_top import dvb_pkg::*; ;
    logic        clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0;
    logic [4:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, rd;
    logic        avs_waitrequest, bus_request_pin, sack_pin, bbsy_pin, intr_pin;
    logic        grant_out_pin, dma_owner_active_n_pin, bus_grant, npr_grant;
    logic        chan_a_irq_enable, chan_b_irq_enable, irq_cond_a, irq_cond_b;
    logic        dma_cycle_request_n, ack_release_permit_n, transfer_done_flag;
    logic        slave_sync;
    logic [8:2]  vector_pin;
    logic [8:3]  jumper = 0;
    logic [3:0]  irq_pins;
    logic [5:0]  idle_pins;
    assign irq_pins  = {irq_cond_b, irq_cond_a, chan_b_irq_enable, chan_a_irq_enable};
    assign idle_pins = {bus_grant, npr_grant, slave_sync, transfer_done_flag,
                        ack_release_permit_n, dma_cycle_request_n};
    int          err_total = 0, comparisons = 0, n_intr = 0, n_dma = 0;
    int          total = 0, cnt, c, t, i0, n0;
    int          ctrl_tbl [4] = '{32'h15, 32'h1A, 32'h1F, 32'h1C};
    int          nint_tbl [4] = '{1, 1, 2, 0};
    dvb_host      u_dut (.*);
    dvb_dev_model u_dev (.*);
    always #20 clk_sys = ~clk_sys;
    always @(posedge intr_pin) n_intr++;
    always @(negedge dma_owner_active_n_pin) n_dma++;
    // ==========================================================
    // Bus master and comparison tasks
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, d};
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0 && k < 50) begin @(posedge clk_sys); k++; end
        if (k == 50) err_total++;
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'b00;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin $display("MISMATCH %s exp %h got %h", n, e, g); err_total++; end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] vexp(input logic b);
        return {23'h0, jumper, b, 2'b00};
    endfunction
    initial begin #(40 * 30000); err_total++; print_verdict(); end
    initial
    begin
        void'($urandom(32'hf4e2af69));
        repeat (5) @(posedge clk_sys);
        resetn <= 1;
        @(posedge clk_sys);
        chk("req_n", 1, dma_cycle_request_n);
        av(0, OFS_CTRL, 0);  chk("ctrl", 0, rd);
        av(0, OFS_COUNT, 0); chk("count", 1, rd);
        av(1, 5'h14, 32'hFFFF_FFFF);
        av(0, 5'h14, 0);     chk("unmapped", 0, rd);
        $display("test reset done");
        // Interrupt channels: A, B, both at once, enables off
        for (c = 0; c < 4; c++)
        begin
            av(1, OFS_CTRL, 32'h10);
            jumper <= 6'($urandom);
            i0 = n_intr;
            av(1, OFS_CTRL, ctrl_tbl[c]);
            repeat (200) @(posedge clk_sys);
            chk("intr count", nint_tbl[c], n_intr - i0);
            chk("irq pins", ctrl_tbl[c] & 15, irq_pins);
            if (c < 3)
            begin
                av(0, OFS_VECTOR, 0); chk("vector", vexp(c != 0), rd);
                av(0, OFS_STATUS, 0); chk("vec valid", 0, rd[STAT_VEC_VLD]);
            end
            $display("test irq %0d done", c);
        end
        // Direct transfers: count 0 refused, single, burst; GO twice
        for (t = 0; t < 4; t++)
        begin
            cnt = (t == 0) ? 0 : 1 + $urandom % 5;
            av(1, OFS_COUNT, 32'(cnt));
            av(1, OFS_CTRL, (t >= 2) ? 32'h30 : 32'h10);
            {i0, n0} = {n_intr, n_dma};
            av(1, OFS_GO, 1);
            av(1, OFS_GO, 1);
            repeat (60) @(posedge clk_sys);
            for (c = 0; c < 200; c++) begin av(0, OFS_STATUS, 0); if (rd[0] === 1'b0) break; end
            total += cnt;
            chk("dma cycles", cnt, n_dma - n0);
            chk("no irq", i0, n_intr);
            chk("done count", total & 32'hFF, rd[15:8]);
            chk("dma idle", 0, rd[STAT_DMA_BUSY]);
            chk("req released", 1, dma_cycle_request_n);
            chk("idle pins", 1, idle_pins);
            $display("test dma %0d done", t);
        end
        print_verdict();
    end
endmodule // dual_vector_and_dma_bus_request_tb_top
